// *** tpcc_map.svh ***
/*
  constants of the pin configuration c block: register addresses, reset
  values, bit positions and pin indices.
  assumes it is included by its bare name, once or many times.
*/
`ifndef TPCC_MAP_SVH
`define TPCC_MAP_SVH

// ----------------------------------------------------------------------
// register addresses on the configuration port
// ----------------------------------------------------------------------
`define TPCC_ADDR_PIN_CONFIG_C 8'h0f
`define TPCC_ADDR_FUNC_SEL     8'h1c
`define TPCC_ADDR_MISC         8'h1d
`define TPCC_ADDR_PNP          8'h1e
`define TPCC_ADDR_PIN_DATA     8'h1f
`define TPCC_ADDR_IRQ_STATUS   8'h20
`define TPCC_ADDR_IRQ_ENABLE   8'h21
`define TPCC_ADDR_IRQ_CLEAR    8'h22
`define TPCC_ADDR_PIN_STATE    8'h23

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TPCC_RST_PIN_CONFIG_C  8'h03
`define TPCC_RST_FUNC_SEL      6'h00
`define TPCC_RST_MISC          3'h0
`define TPCC_RST_PNP           5'h00
`define TPCC_RST_PIN_DATA      6'h00
`define TPCC_RST_IRQ           2'h0
`define TPCC_READ_IDLE         8'h00

// ----------------------------------------------------------------------
// shared pin indices, interrupt bits, isa interrupt levels
// ----------------------------------------------------------------------
`define TPCC_NUM_PINS          6
`define TPCC_PIN_USER5         0
`define TPCC_PIN_USER6         1
`define TPCC_PIN_RXC           2
`define TPCC_PIN_TXCMD         3
`define TPCC_PIN_TXDATA        4
`define TPCC_PIN_ANTSEL        5
`define TPCC_IRQ_EXT           0
`define TPCC_IRQ_BUSY          1
`define TPCC_ISA_LEVEL_USER5   4'h4
`define TPCC_ISA_LEVEL_USER6   4'h5
`define TPCC_ISA_LEVEL_RXC     4'ha
`define TPCC_STRAP_SETTLE      2'h2

`endif

// *** tpcc_pkg.sv ***
/*
  types of the pin configuration c block: register layouts as packed structs.
  assumes tpcc_map.svh for the numeric constants.
*/
package tpcc_pkg;

  // pin configuration c, bit 7 down to bit 0
  typedef struct packed {
    logic antenna_select_pin_enable;
    logic tx_data_pin_enable;
    logic tx_command_pin_enable;
    logic rx_clock_pin_enable;
    logic user_pin6_enable;
    logic user_pin5_enable;
    logic activity_led_enable;
    logic status_change_function;
  } tpcc_cfg_s;

  // alternate function selects of the shared pins
  typedef struct packed {
    logic rx_clock_function_bit;
    logic antenna_function_bit;
    logic tx_data_function_bit;
    logic tx_command_function_bit;
    logic user_pin6_function;
    logic user_pin5_function;
  } tpcc_sel_s;

  // loose control bits
  typedef struct packed {
    logic receive_clock_enable_bit;
    logic antenna_select_enable;
    logic status_change_data;
  } tpcc_misc_s;

  // plug and play interrupt level and type
  typedef struct packed {
    logic       irq_active_high;
    logic [3:0] irq_level;
  } tpcc_pnp_s;

  // processor interrupt layout: status, enable and clear share it
  typedef struct packed {
    logic channel_busy;
    logic external_signal;
  } tpcc_irq_s;

endpackage

// *** tpcc_pin_func.sv ***
/*
  one shared pin: picks isa interrupt, alternate or software drive and
  registers the pin value and its output enable.
  assumes all inputs come from logic on mclk_i.
*/
`timescale 1ns/100ps
module tpcc_pin_func
  import tpcc_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic pin_en_i,
  input  wire logic pc_mode_i,
  input  wire logic pc_only_i,
  input  wire logic func_i,
  input  wire logic gate_i,
  input  wire logic alt_val_i,
  input  wire logic sw_val_i,
  input  wire logic isa_sel_i,
  input  wire logic isa_val_i,
  output logic      pin_out_o,
  output logic      pin_oe_o
);

  logic next_out;
  logic next_oe;

  // isa interrupt routing wins, then the enable bit decides on any drive
  always_comb
  begin
    next_out = sw_val_i;
    next_oe  = 1'b0;
    if (!pc_mode_i && isa_sel_i)
    begin
      next_out = isa_val_i;
      next_oe  = 1'b1;
    end
    else if (pin_en_i && (pc_mode_i || !pc_only_i)) // RQ13
    begin
      next_out = func_i ? alt_val_i : sw_val_i;
      next_oe  = func_i ? gate_i : 1'b1;
    end
  end

  // registered so the pad sees no decode glitches
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pin_out_o <= 1'b0;
      pin_oe_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      pin_out_o <= next_out;
      pin_oe_o  <= next_oe;
    end
  end

endmodule // tpcc_pin_func

// *** tpcc_top.sv ***
/*
  pin configuration c register, companion control registers, shared pin
  function logic, status-change pin and processor interrupt from user pins.
  assumes a single-cycle configuration port on mclk_i, pin inputs and the
  bus-mode strap asynchronous, all other inputs synchronous to mclk_i.
*/
// Function
// [RQ1] status-change function 1: pin is nand of status data and wake bit.
// [RQ2] status-change function 0: pin is inverse of status data.
// [RQ3] status-change output only in pc card mode; isa leaves pin undriven.
// [RQ4] user pin 6 interrupts processor via enable and sticky status.
// [RQ5] user pin 5 interrupts processor via enable and sticky status.
// [RQ6] antenna pin from bit 7, function bit, select enable, strap.
// [RQ7] transmit data pin direction from bit 6, function bit, strap.
// [RQ8] transmit command pin from bit 5, function, receive clock enable, strap.
// [RQ9] receive clock pin from bit 4, function, pnp level and type, strap.
// [RQ10] user pin 6 from bit 3, function, pnp level and type, strap.
// [RQ11] user pin 5 from bit 2, function, pnp level and type, strap.
// [RQ12] bit 1 drives activity led; bits 1 and 0 reset to one.
// [RQ13] enable 1 drives pin both ways; enable 0 leaves pin high impedance; isa mode drives the pin the pnp level selects, even with enable 0.
// [RQ14] register at index 0fh reads back last written value.
`timescale 1ns/100ps
`include "tpcc_map.svh"
module tpcc_top
  import tpcc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        bus_mode_strap_i,
  input  wire logic        card_wake_bit_i,
  input  wire logic        activity_i,
  input  wire logic [5:0]  alt_data_i,
  input  wire logic        host_irq_req_i,
  input  wire logic [5:0]  pin_in_i,
  output logic      [5:0]  pin_out_o,
  output logic      [5:0]  pin_oe_o,
  output logic             act_out_o,
  output logic             act_oe_o,
  output logic             stschg_out_o,
  output logic             stschg_oe_o,
  output logic             pc_mode_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------------
  // registers and internal state
  // ----------------------------------------------------------------------
  tpcc_cfg_s   cfg;
  tpcc_sel_s   sel;
  tpcc_misc_s  misc;
  tpcc_pnp_s   pnp;
  tpcc_irq_s   irq_status;
  tpcc_irq_s   irq_enable;
  logic [5:0]  pin_data;
  logic [5:0]  pin_meta;
  logic [5:0]  pin_sync;
  logic [5:0]  pin_prev;
  logic        strap_meta;
  logic        strap_sync;
  logic [1:0]  strap_cnt;
  logic        strap_done;
  logic        pc_mode;
  logic        isa_irq_val;
  logic [5:0]  isa_sel;
  logic [5:0]  pin_func;
  logic [5:0]  pin_gate;
  logic [5:0]  pin_en;
  logic [5:0]  pc_only;
  tpcc_irq_s   irq_event;
  logic [7:0]  next_rdata;

  // write strobe decode, reused for every register
  function automatic logic wr_hit(input logic [7:0] addr);
    wr_hit = ce_i && reg_wr_i && (reg_addr_i == addr);
  endfunction

  // ----------------------------------------------------------------------
  // input synchronisers and strap capture
  // ----------------------------------------------------------------------
  // two flops for pins plus a delay flop; logic reads the second stage and the delayed third
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pin_meta   <= 6'h00;
      pin_sync   <= 6'h00;
      pin_prev   <= 6'h00;
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
    end
    else if (ce_i)
    begin
      pin_meta   <= pin_in_i;
      pin_sync   <= pin_meta;
      pin_prev   <= pin_sync;
      strap_meta <= bus_mode_strap_i;
      strap_sync <= strap_meta;
    end
  end

  // strap taken once after release, when the synchroniser has filled
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
      pc_mode    <= 1'b0;
    end
    else if (ce_i && !strap_done)
    begin
      if (strap_cnt == `TPCC_STRAP_SETTLE)
      begin
        pc_mode    <= strap_sync;
        strap_done <= 1'b1;
      end
      else
      begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end
  end

  assign pc_mode_o = pc_mode;

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  // pin configuration c; led and status-change function reset high
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      cfg <= tpcc_cfg_s'(`TPCC_RST_PIN_CONFIG_C); // RQ12
    else if (wr_hit(`TPCC_ADDR_PIN_CONFIG_C))
      cfg <= tpcc_cfg_s'(reg_wdata_i); // RQ14
  end

  // function selects, loose bits, pnp settings and software pin data
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      sel      <= tpcc_sel_s'(`TPCC_RST_FUNC_SEL);
      misc     <= tpcc_misc_s'(`TPCC_RST_MISC);
      pnp      <= tpcc_pnp_s'(`TPCC_RST_PNP);
      pin_data <= `TPCC_RST_PIN_DATA;
    end
    else
    begin
      if (wr_hit(`TPCC_ADDR_FUNC_SEL))
        sel <= tpcc_sel_s'(reg_wdata_i[5:0]);
      if (wr_hit(`TPCC_ADDR_MISC))
        misc <= tpcc_misc_s'(reg_wdata_i[2:0]);
      if (wr_hit(`TPCC_ADDR_PNP))
        pnp <= tpcc_pnp_s'(reg_wdata_i[4:0]);
      if (wr_hit(`TPCC_ADDR_PIN_DATA))
        pin_data <= reg_wdata_i[5:0];
    end
  end

  // ----------------------------------------------------------------------
  // processor interrupt from user pins 5 and 6
  // ----------------------------------------------------------------------
  // rising edges of the synchronised pins, independent of pin config
  assign irq_event.external_signal = pin_sync[`TPCC_PIN_USER6] &&
                                     !pin_prev[`TPCC_PIN_USER6];
  assign irq_event.channel_busy    = pin_sync[`TPCC_PIN_USER5] &&
                                     !pin_prev[`TPCC_PIN_USER5];

  // sticky status: an edge in the clear cycle survives the clear
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      irq_status <= tpcc_irq_s'(`TPCC_RST_IRQ);
    else if (ce_i)
    begin
      if (wr_hit(`TPCC_ADDR_IRQ_CLEAR))
        irq_status <= tpcc_irq_s'((irq_status & ~reg_wdata_i[1:0]) | irq_event);
      else
        irq_status <= irq_status | irq_event; // RQ4 RQ5
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      irq_enable <= tpcc_irq_s'(`TPCC_RST_IRQ);
    else if (wr_hit(`TPCC_ADDR_IRQ_ENABLE))
      irq_enable <= tpcc_irq_s'(reg_wdata_i[1:0]);
  end

  // level output while any enabled status bit stands
  assign irq_o = |(irq_status & irq_enable); // RQ4 RQ5

  // ----------------------------------------------------------------------
  // shared pin function selection
  // ----------------------------------------------------------------------
  // isa interrupt polarity from the pnp type bit
  assign isa_irq_val = pnp.irq_active_high ? host_irq_req_i : !host_irq_req_i;

  // per-pin enable, alternate select and gating
  always_comb
  begin
    isa_sel  = 6'h00;
    pin_en   = 6'h00;
    pin_func = 6'h00;
    pin_gate = 6'h3f;
    pc_only  = 6'h00;
    // user pins and receive clock double as isa interrupt lines
    isa_sel[`TPCC_PIN_USER5]  = (pnp.irq_level == `TPCC_ISA_LEVEL_USER5); // RQ11
    isa_sel[`TPCC_PIN_USER6]  = (pnp.irq_level == `TPCC_ISA_LEVEL_USER6); // RQ10
    isa_sel[`TPCC_PIN_RXC]    = (pnp.irq_level == `TPCC_ISA_LEVEL_RXC); // RQ9
    pin_en[`TPCC_PIN_USER5]   = cfg.user_pin5_enable; // RQ11
    pin_en[`TPCC_PIN_USER6]   = cfg.user_pin6_enable; // RQ10
    pin_en[`TPCC_PIN_RXC]     = cfg.rx_clock_pin_enable; // RQ9
    pin_en[`TPCC_PIN_TXCMD]   = cfg.tx_command_pin_enable; // RQ8
    pin_en[`TPCC_PIN_TXDATA]  = cfg.tx_data_pin_enable; // RQ7
    pin_en[`TPCC_PIN_ANTSEL]  = cfg.antenna_select_pin_enable; // RQ6
    pin_func[`TPCC_PIN_USER5] = sel.user_pin5_function;
    pin_func[`TPCC_PIN_USER6] = sel.user_pin6_function;
    pin_func[`TPCC_PIN_RXC]   = sel.rx_clock_function_bit;
    pin_func[`TPCC_PIN_TXCMD] = sel.tx_command_function_bit;
    pin_func[`TPCC_PIN_TXDATA] = sel.tx_data_function_bit;
    pin_func[`TPCC_PIN_ANTSEL] = sel.antenna_function_bit;
    // alternate command and antenna drive need their own enables
    pin_gate[`TPCC_PIN_TXCMD]  = misc.receive_clock_enable_bit; // RQ8
    pin_gate[`TPCC_PIN_ANTSEL] = misc.antenna_select_enable; // RQ6
    // these pins are isa address lines, so never driven in isa mode
    pc_only[`TPCC_PIN_TXCMD]  = 1'b1;
    pc_only[`TPCC_PIN_TXDATA] = 1'b1; // RQ7
    pc_only[`TPCC_PIN_ANTSEL] = 1'b1;
  end

  // one registered pin driver per shared pin
  for (genvar gi = 0; gi < `TPCC_NUM_PINS; gi++)
  begin : g_pin
    tpcc_pin_func u_pin (
      .mclk_i    (mclk_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .pin_en_i  (pin_en[gi]),
      .pc_mode_i (pc_mode),
      .pc_only_i (pc_only[gi]),
      .func_i    (pin_func[gi]),
      .gate_i    (pin_gate[gi]),
      .alt_val_i (alt_data_i[gi]),
      .sw_val_i  (pin_data[gi]),
      .isa_sel_i (isa_sel[gi]),
      .isa_val_i (isa_irq_val),
      .pin_out_o (pin_out_o[gi]),
      .pin_oe_o  (pin_oe_o[gi])
    );
  end

  // ----------------------------------------------------------------------
  // activity led and status-change pins
  // ----------------------------------------------------------------------
  // led is active low; status-change pin is the bale input in isa mode
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      act_out_o    <= 1'b1;
      act_oe_o     <= 1'b0;
      stschg_out_o <= 1'b1;
      stschg_oe_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      act_out_o   <= !activity_i;
      act_oe_o    <= cfg.activity_led_enable; // RQ12
      stschg_oe_o <= pc_mode; // RQ3
      if (cfg.status_change_function)
        stschg_out_o <= !(misc.status_change_data && card_wake_bit_i); // RQ1
      else
        stschg_out_o <= !misc.status_change_data; // RQ2
    end
  end

  // ----------------------------------------------------------------------
  // read port: data stands only in the cycle after the strobe
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_rdata = `TPCC_READ_IDLE;
    case (reg_addr_i)
      `TPCC_ADDR_PIN_CONFIG_C: next_rdata = cfg; // RQ14
      `TPCC_ADDR_FUNC_SEL:     next_rdata = {2'h0, sel};
      `TPCC_ADDR_MISC:         next_rdata = {5'h00, misc};
      `TPCC_ADDR_PNP:          next_rdata = {3'h0, pnp};
      `TPCC_ADDR_PIN_DATA:     next_rdata = {2'h0, pin_data};
      `TPCC_ADDR_IRQ_STATUS:   next_rdata = {6'h00, irq_status};
      `TPCC_ADDR_IRQ_ENABLE:   next_rdata = {6'h00, irq_enable};
      `TPCC_ADDR_PIN_STATE:    next_rdata = {1'b0, pc_mode, pin_sync};
      default:                 next_rdata = `TPCC_READ_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= `TPCC_READ_IDLE;
    else if (ce_i)
      reg_rdata_o <= reg_rd_i ? next_rdata : `TPCC_READ_IDLE;
  end

  // ----------------------------------------------------------------------
  // assertions and cover points
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_stschg_nand: assert property (ce_i && cfg.status_change_function |=> // RQ1
    stschg_out_o == !($past(misc.status_change_data) && $past(card_wake_bit_i)))
    else $error("status-change pin not nand of data and wake");

  a_stschg_invert: assert property (ce_i && !cfg.status_change_function |=> // RQ2
    stschg_out_o == !$past(misc.status_change_data))
    else $error("status-change pin not inverse of data");

  a_stschg_isa_off: assert property (ce_i && strap_done && !pc_mode |=> // RQ3
    !stschg_oe_o)
    else $error("status-change pin driven in isa mode");

  a_user6_irq: assert property (ce_i && irq_event.external_signal && // RQ4
    irq_enable.external_signal && !wr_hit(`TPCC_ADDR_IRQ_ENABLE) |=> irq_o)
    else $error("user pin 6 edge did not raise interrupt");

  a_user5_irq: assert property (ce_i && irq_event.channel_busy && // RQ5
    irq_enable.channel_busy && !wr_hit(`TPCC_ADDR_IRQ_ENABLE) |=> irq_o)
    else $error("user pin 5 edge did not raise interrupt");

  a_antsel_gate: assert property (ce_i && pc_mode && cfg.antenna_select_pin_enable && // RQ6
    sel.antenna_function_bit && !misc.antenna_select_enable |=> !pin_oe_o[`TPCC_PIN_ANTSEL])
    else $error("antenna pin driven without select enable");

  a_txdata_isa: assert property (ce_i && !pc_mode |=> !pin_oe_o[`TPCC_PIN_TXDATA]) // RQ7
    else $error("transmit data pin driven in isa mode");

  a_txcmd_drive: assert property (ce_i && pc_mode && cfg.tx_command_pin_enable && // RQ8
    !sel.tx_command_function_bit |=> pin_oe_o[`TPCC_PIN_TXCMD])
    else $error("transmit command pin not driven");

  a_rxc_isa_irq: assert property (ce_i && !pc_mode && // RQ9
    pnp.irq_level == `TPCC_ISA_LEVEL_RXC |=> pin_oe_o[`TPCC_PIN_RXC] &&
    pin_out_o[`TPCC_PIN_RXC] == $past(isa_irq_val))
    else $error("receive clock pin not carrying isa interrupt");

  // rst_n_i in the antecedent skips the release edge, where the pad is still reset
  a_led_enable: assert property (ce_i && rst_n_i |=> // RQ12
    act_oe_o == $past(cfg.activity_led_enable))
    else $error("led drive does not follow enable bit");

  a_pin_hiz: assert property (ce_i && !cfg.user_pin5_enable && // RQ13
    pnp.irq_level != `TPCC_ISA_LEVEL_USER5 |=> !pin_oe_o[`TPCC_PIN_USER5])
    else $error("user pin 5 driven while disabled");

  a_cfg_readback: assert property (wr_hit(`TPCC_ADDR_PIN_CONFIG_C) ##1 // RQ14
    (ce_i && reg_rd_i && reg_addr_i == `TPCC_ADDR_PIN_CONFIG_C &&
    !reg_wr_i) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("pin configuration c readback mismatch");

  c_pc_mode:    cover property (strap_done && pc_mode && stschg_oe_o);
  c_isa_irq:    cover property (!pc_mode && strap_done && pin_oe_o[`TPCC_PIN_USER6]);
  c_proc_irq:   cover property (!irq_o ##1 irq_o);
  c_clear_race: cover property (wr_hit(`TPCC_ADDR_IRQ_CLEAR) && |irq_event);

endmodule // tpcc_top

// *** tb.sv ***
/*
  self-checking bench for the pin configuration c block: register rows,
  status-change pin, shared pin functions, activity led, processor
  interrupt, then isa strap mode.
  assumes tpcc_top, tpcc_pkg and tpcc_map.svh; ce_i is dropped once.
*/
`timescale 1ns/100ps
`include "tpcc_map.svh"
module tb;
  // ----------------------------------------------------------------------
  // clock, stimulus and bookkeeping
  // ----------------------------------------------------------------------
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp;} tpcc_row_s;
  logic        mclk_i;
  logic        rst_n_i;
  logic        ce_i;
  logic [7:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_rdata_o;
  logic        bus_mode_strap_i;
  logic        card_wake_bit_i;
  logic        activity_i;
  logic [5:0]  alt_data_i;
  logic        host_irq_req_i;
  logic [5:0]  pin_in_i;
  logic [5:0]  pin_out_o;
  logic [5:0]  pin_oe_o;
  logic        act_out_o;
  logic        act_oe_o;
  logic        stschg_out_o;
  logic        stschg_oe_o;
  logic        pc_mode_o;
  logic        irq_o;
  int          miscompares;
  int          samples_checked;
  int          k;
  // write then read back; status and unmapped places read zero
  tpcc_row_s   rows [9] = '{
    '{8'h0f, 8'h55, 8'h55}, '{8'h0f, 8'haa, 8'haa}, '{8'h1c, 8'h3f, 8'h3f},
    '{8'h1d, 8'h07, 8'h07}, '{8'h1e, 8'h1f, 8'h1f}, '{8'h1f, 8'h3f, 8'h3f},
    '{8'h21, 8'h03, 8'h03}, '{8'h20, 8'hff, 8'h00}, '{8'h05, 8'hff, 8'h00}};

  tpcc_top i_tpcc_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .bus_mode_strap_i(bus_mode_strap_i),
    .card_wake_bit_i(card_wake_bit_i), .activity_i(activity_i), .alt_data_i(alt_data_i),
    .host_irq_req_i(host_irq_req_i), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .act_out_o(act_out_o), .act_oe_o(act_oe_o),
    .stschg_out_o(stschg_out_o), .stschg_oe_o(stschg_oe_o), .pc_mode_o(pc_mode_o),
    .irq_o(irq_o));

  // free-running 200 mhz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // ----------------------------------------------------------------------
  // tasks: one cycle strobes, driven at a rising edge, idle cycle after
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // pins lag the registers by one cycle; three edges leave margin
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic do_reset(input logic strap);
    @(posedge mclk_i);
    bus_mode_strap_i <= strap;
    rst_n_i          <= 1'b0;
    repeat (10) @(posedge mclk_i);
    rst_n_i          <= 1'b1;
    settle(6);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog far beyond the roughly 200 cycles the tests need
  initial
  begin
    #20000;
    miscompares++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin : main
    logic [7:0] d;
    {rst_n_i, reg_wr_i, reg_rd_i, card_wake_bit_i, activity_i, host_irq_req_i} = '0;
    {reg_addr_i, reg_wdata_i, alt_data_i, pin_in_i} = '0;
    bus_mode_strap_i = 1'b1;
    ce_i = 1'b1;
    samples_checked = 0;
    miscompares = 0;
    do_reset(1'b1);
    rd(`TPCC_ADDR_PIN_CONFIG_C, d);
    chk(d, 8'h03);
    chk({6'h0, act_oe_o, pc_mode_o}, 8'h03);
    $display("test reset done");

    // ordinary register rows
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, d);
      chk(d, rows[i].rexp);
    end
    $display("test register rows done");

    // status-change pin in pc card mode
    wr(`TPCC_ADDR_MISC, 8'h01);
    wr(`TPCC_ADDR_PIN_CONFIG_C, 8'h03);
    card_wake_bit_i <= 1'b1;
    settle(3);
    chk({6'h0, stschg_oe_o, stschg_out_o}, 8'h02);
    @(posedge mclk_i) card_wake_bit_i <= 1'b0;
    settle(3);
    chk({7'h0, stschg_out_o}, 8'h01);
    wr(`TPCC_ADDR_PIN_CONFIG_C, 8'h02);
    card_wake_bit_i <= 1'b1;
    settle(3);
    chk({7'h0, stschg_out_o}, 8'h00);
    wr(`TPCC_ADDR_MISC, 8'h00);
    settle(3);
    chk({7'h0, stschg_out_o}, 8'h01);
    $display("test status change done");

    // shared pins: software drive, then alternate with gates shut and open
    wr(`TPCC_ADDR_PIN_DATA, 8'h2a);
    wr(`TPCC_ADDR_FUNC_SEL, 8'h00);
    wr(`TPCC_ADDR_PIN_CONFIG_C, 8'hfe);
    settle(3);
    chk({2'h0, pin_oe_o}, 8'h3f);
    chk({2'h0, pin_out_o}, 8'h2a);
    wr(`TPCC_ADDR_FUNC_SEL, 8'h3f);
    alt_data_i <= 6'h15;
    settle(3);
    chk({2'h0, pin_oe_o}, 8'h17);
    chk({2'h0, pin_out_o}, 8'h15);
    wr(`TPCC_ADDR_MISC, 8'h06);
    settle(3);
    chk({2'h0, pin_oe_o}, 8'h3f);
    wr(`TPCC_ADDR_PIN_CONFIG_C, 8'h02);
    activity_i <= 1'b1;
    settle(3);
    chk({2'h0, pin_oe_o}, 8'h00);
    chk({6'h0, act_oe_o, act_out_o}, 8'h02);
    wr(`TPCC_ADDR_PIN_CONFIG_C, 8'h00);
    settle(3);
    chk({7'h0, act_oe_o}, 8'h00);
    $display("test shared pins done");

    // processor interrupt from user pins: raise, mask, clear
    wr(`TPCC_ADDR_IRQ_CLEAR, 8'h03);
    wr(`TPCC_ADDR_IRQ_ENABLE, 8'h01);
    pin_in_i[1] <= 1'b1;
    settle(6);
    chk({7'h0, irq_o}, 8'h01);
    rd(`TPCC_ADDR_IRQ_STATUS, d);
    chk(d, 8'h01);
    wr(`TPCC_ADDR_IRQ_ENABLE, 8'h00);
    settle(2);
    chk({7'h0, irq_o}, 8'h00);
    wr(`TPCC_ADDR_IRQ_CLEAR, 8'h01);
    rd(`TPCC_ADDR_IRQ_STATUS, d);
    chk(d, 8'h00);
    wr(`TPCC_ADDR_IRQ_ENABLE, 8'h02);
    pin_in_i[0] <= 1'b1;
    settle(6);
    chk({7'h0, irq_o}, 8'h01);
    rd(`TPCC_ADDR_IRQ_STATUS, d);
    chk(d, 8'h02);
    wr(`TPCC_ADDR_IRQ_CLEAR, 8'h02);
    settle(2);
    chk({7'h0, irq_o}, 8'h00);
    $display("test interrupt done");

    // isa strap: card-only pins and status change stay undriven
    do_reset(1'b0);
    wr(`TPCC_ADDR_PIN_DATA, 8'h3f);
    wr(`TPCC_ADDR_PIN_CONFIG_C, 8'hfc);
    settle(3);
    chk({2'h0, pin_oe_o}, 8'h07);
    chk({6'h0, stschg_oe_o, pc_mode_o}, 8'h00);
    rd(`TPCC_ADDR_PIN_STATE, d);
    chk(d, 8'h03);
    // host interrupt level routed to user5, user6, rxc in both polarities
    @(posedge mclk_i) host_irq_req_i <= 1'b1;
    wr(`TPCC_ADDR_PIN_CONFIG_C, 8'h00);
    for (k = 0; k < 3; k++)
    begin
      wr(`TPCC_ADDR_PNP, (k == 2) ? 8'h1a : 8'h14 + 8'(k));
      settle(3);
      chk({6'h0, pin_oe_o[k], pin_out_o[k]}, 8'h03);
      wr(`TPCC_ADDR_PNP, (k == 2) ? 8'h0a : 8'h04 + 8'(k));
      settle(3);
      chk({6'h0, pin_oe_o[k], pin_out_o[k]}, 8'h02);
    end
    $display("test isa mode done");
    // clock enable low: a write in that cycle must not land
    @(posedge mclk_i) ce_i <= 1'b0;
    wr(`TPCC_ADDR_PIN_CONFIG_C, 8'hff);
    ce_i <= 1'b1;
    rd(`TPCC_ADDR_PIN_CONFIG_C, d);
    chk(d, 8'h00);
    $display("test clock enable done");
    wrap_up();
  end
endmodule // tb
